// file: core/tmbw_device.sv
// Device end: writes incoming trace bytes into a buffer in system memory
// Functional notes
// - Circular mode writes nonstop, wrapping over oldest
// - Reader fetches circular buffer only after stop
// - Circular mode is always present
// - FIFO modes stall writes while buffer full
// - Mode one: reads served through read-data port
// - Mode two: software reports consumed pointer
// - Both FIFO modes are optional
// - Events on trigger, abort and buffer full
// - Events sent as configured message interrupts
// - Variable-size trace needs alignment synchronisation
// - Formatter stage pads trace to word alignment unless a FIFO buffer is full
// - Write pointer advances one per byte
// - Pointer wraps at end; circular sets full
// - FIFO modes: full from level versus watermark
// - Start writes at current pointer, no reload
module tmbw_device (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic fmt_en,
  input wire logic stop_event,
  output tmbw_pkg::tmbw_state_t state,
  tmbw_if.dev lnk
);
  localparam int AW = tmbw_pkg::ADDR_W;
  localparam int BW = tmbw_pkg::BYTE_W;
  localparam int EW = tmbw_pkg::EVT_W;

  tmbw_pkg::tmbw_state_t st_q, st_d;
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW-1:0] wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
  logic [AW-1:0] msi_addr_q, msi_addr_d;
  logic [tmbw_pkg::MSI_DW-1:0] msi_data_q, msi_data_d;
  logic [BW-1:0] wr_data_q, wr_data_d, rd_data_q, rd_data_d;
  logic full_q, full_d, ffull_q, ffull_d;
  logic wr_vld_q, wr_vld_d, wr_wait_q, wr_wait_d;
  logic rd_vld_q, rd_vld_d, rd_wait_q, rd_wait_d;
  logic rd_out_q, rd_out_d, rd_empty_q, rd_empty_d;
  logic msi_vld_q, msi_vld_d;
  logic [EW-1:0] evt_q, evt_d, evt_set;
  logic [AW-1:0] size_b, end_a, wp_inc, rp_inc, level, thresh;
  logic circ, swf1, swf2, wrap, busy, block, empty, lvl_full;
  logic open_in, take, pad_need, pad;

  always_comb begin
    circ = lnk.mode == tmbw_pkg::MODE_CIRC;
    swf1 = lnk.mode == tmbw_pkg::MODE_SWF1;
    swf2 = lnk.mode == tmbw_pkg::MODE_SWF2;
    size_b = lnk.buffer_size_words << tmbw_pkg::WORD_SHIFT;
    end_a = lnk.buffer_base_address + size_b;
    wrap = (wp_q + tmbw_pkg::ADDR_ONE) == end_a;
    wp_inc = wrap ? lnk.buffer_base_address
                  : wp_q + tmbw_pkg::ADDR_ONE;
    rp_inc = ((rp_q + tmbw_pkg::ADDR_ONE) == end_a)
           ? lnk.buffer_base_address : rp_q + tmbw_pkg::ADDR_ONE;
    if (ffull_q) begin
      level = size_b;
    end else if (wp_q >= rp_q) begin
      level = wp_q - rp_q;
    end else begin
      level = wp_q - rp_q + size_b;
    end
    thresh = (lnk.buffer_size_words - lnk.buffer_watermark_words)
           << tmbw_pkg::WORD_SHIFT;
    lvl_full = level >= thresh;
    empty = (rp_q == wp_q) && !ffull_q && !wr_vld_q && !wr_wait_q;
    busy = wr_vld_q || wr_wait_q;
    block = !circ && ffull_q;
    open_in = (st_q == tmbw_pkg::ST_RUNNING) && !busy && !block;
    take = open_in && lnk.trc_valid;
    pad_need = fmt_en && (wp_q[tmbw_pkg::ALIGN_W-1:0]
             != tmbw_pkg::ALIGN_ZERO) && !block;
    pad = pad_need && !busy && ((st_q == tmbw_pkg::ST_STOPPING)
        || (st_q == tmbw_pkg::ST_DISABLING));
  end

  always_comb begin
    st_d = st_q;
    wp_d = wp_q;
    rp_d = rp_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    rd_addr_d = rd_addr_q;
    rd_data_d = rd_data_q;
    msi_addr_d = msi_addr_q;
    msi_data_d = msi_data_q;
    full_d = full_q;
    ffull_d = ffull_q;
    wr_vld_d = wr_vld_q;
    wr_wait_d = wr_wait_q;
    rd_vld_d = rd_vld_q;
    rd_wait_d = rd_wait_q;
    rd_out_d = 1'b0;
    rd_empty_d = rd_empty_q;
    msi_vld_d = msi_vld_q;
    evt_set = '0;
    if (lnk.wp_load_valid && st_q == tmbw_pkg::ST_DISABLED) begin
      wp_d = lnk.wp_load_value;
      rp_d = lnk.wp_load_value;
      ffull_d = 1'b0;
    end
    // Memory write channel
    if (wr_vld_q && lnk.mem_wr_ready) begin
      wr_vld_d = 1'b0;
      wr_wait_d = 1'b1;
    end
    if (wr_wait_q && lnk.mem_wr_resp_valid) begin
      wr_wait_d = 1'b0;
      evt_set[tmbw_pkg::EVT_ABORT] = lnk.mem_wr_resp_err;
    end
    // Read-data port fetches one byte from memory at the read pointer
    if (lnk.rd_req && swf1 && !rd_vld_q && !rd_wait_q) begin
      if (empty) begin
        rd_out_d = 1'b1;
        rd_empty_d = 1'b1;
        rd_data_d = tmbw_pkg::EMPTY_BYTE;
      end else begin
        rd_vld_d = 1'b1;
        rd_addr_d = rp_q;
      end
    end
    if (rd_vld_q && lnk.mem_rd_ready) begin
      rd_vld_d = 1'b0;
      rd_wait_d = 1'b1;
    end
    if (rd_wait_q && lnk.mem_rd_resp_valid) begin
      rd_wait_d = 1'b0;
      rd_out_d = 1'b1;
      rd_empty_d = 1'b0;
      rd_data_d = lnk.mem_rd_data;
      rp_d = rp_inc;
      ffull_d = 1'b0;
    end
    if (lnk.software_consumed_pointer_update && swf2) begin
      rp_d = lnk.consumed_ptr;
      if (lnk.consumed_ptr != wp_q) begin
        ffull_d = 1'b0;
      end
    end
    if (!circ) begin
      full_d = lvl_full;
    end
    if (take || pad) begin
      wr_vld_d = 1'b1;
      wr_addr_d = wp_q;
      wr_data_d = take ? lnk.trc_data : tmbw_pkg::PAD_BYTE;
      wp_d = wp_inc;
      if (wrap && circ) begin
        full_d = 1'b1;
      end
      if (!circ && wp_inc == rp_d) begin
        ffull_d = 1'b1;
      end
    end
    evt_set[tmbw_pkg::EVT_TRIG] = lnk.trc_trigger
                               && st_q == tmbw_pkg::ST_RUNNING;
    evt_set[tmbw_pkg::EVT_FULL] = full_d && !full_q;
    case (st_q)
      tmbw_pkg::ST_DISABLED: begin
        if (lnk.capture_enable_control) begin
          st_d = tmbw_pkg::ST_RUNNING;
          full_d = 1'b0;
          evt_set[tmbw_pkg::EVT_FULL] = 1'b0;
        end
      end
      tmbw_pkg::ST_RUNNING: begin
        if (!lnk.capture_enable_control) begin
          st_d = tmbw_pkg::ST_DISABLING;
        end else if (stop_event || evt_set[tmbw_pkg::EVT_ABORT]) begin
          st_d = tmbw_pkg::ST_STOPPING;
        end
      end
      tmbw_pkg::ST_STOPPING: begin
        if (!lnk.capture_enable_control) begin
          st_d = tmbw_pkg::ST_DISABLING;
        end else if (!busy && !pad_need) begin
          st_d = tmbw_pkg::ST_STOPPED;
        end
      end
      tmbw_pkg::ST_STOPPED: begin
        if (!lnk.capture_enable_control) begin
          st_d = tmbw_pkg::ST_DISABLED;
        end
      end
      tmbw_pkg::ST_DISABLING: begin
        if (!busy && !pad_need) begin
          st_d = tmbw_pkg::ST_DISABLED;
        end
      end
      default: begin
        st_d = tmbw_pkg::ST_DISABLED;
      end
    endcase
    evt_d = (evt_q & ~lnk.evt_clear) | evt_set;
    if (msi_vld_q && lnk.msi_ready) begin
      msi_vld_d = 1'b0;
    end
    if ((|evt_set) && lnk.msi_enable && (!msi_vld_q || lnk.msi_ready)) begin
      msi_vld_d = 1'b1;
      msi_addr_d = lnk.msi_addr_cfg;
      msi_data_d = lnk.msi_data_cfg;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= tmbw_pkg::ST_DISABLED;
      wp_q <= tmbw_pkg::ADDR_ZERO;
      rp_q <= tmbw_pkg::ADDR_ZERO;
      wr_addr_q <= tmbw_pkg::ADDR_ZERO;
      rd_addr_q <= tmbw_pkg::ADDR_ZERO;
      msi_addr_q <= tmbw_pkg::ADDR_ZERO;
      msi_data_q <= '0;
      wr_data_q <= '0;
      rd_data_q <= '0;
      full_q <= 1'b0;
      ffull_q <= 1'b0;
      wr_vld_q <= 1'b0;
      wr_wait_q <= 1'b0;
      rd_vld_q <= 1'b0;
      rd_wait_q <= 1'b0;
      rd_out_q <= 1'b0;
      rd_empty_q <= 1'b0;
      msi_vld_q <= 1'b0;
      evt_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      wr_addr_q <= wr_addr_d;
      rd_addr_q <= rd_addr_d;
      msi_addr_q <= msi_addr_d;
      msi_data_q <= msi_data_d;
      wr_data_q <= wr_data_d;
      rd_data_q <= rd_data_d;
      full_q <= full_d;
      ffull_q <= ffull_d;
      wr_vld_q <= wr_vld_d;
      wr_wait_q <= wr_wait_d;
      rd_vld_q <= rd_vld_d;
      rd_wait_q <= rd_wait_d;
      rd_out_q <= rd_out_d;
      rd_empty_q <= rd_empty_d;
      msi_vld_q <= msi_vld_d;
      evt_q <= evt_d;
    end
  end

  assign state = st_q;
  assign lnk.trc_ready = open_in;
  assign lnk.mem_wr_valid = wr_vld_q;
  assign lnk.mem_wr_addr = wr_addr_q;
  assign lnk.mem_wr_data = wr_data_q;
  assign lnk.mem_rd_valid = rd_vld_q;
  assign lnk.mem_rd_addr = rd_addr_q;
  assign lnk.msi_valid = msi_vld_q;
  assign lnk.msi_addr = msi_addr_q;
  assign lnk.msi_data = msi_data_q;
  assign lnk.rd_valid = rd_out_q;
  assign lnk.buffer_read_data_port = rd_data_q;
  assign lnk.rd_empty = rd_empty_q;
  assign lnk.buffer_full_flag = full_q;
  assign lnk.capt_ready = (st_q == tmbw_pkg::ST_DISABLED)
                       || (st_q == tmbw_pkg::ST_STOPPED);
  assign lnk.evt_status = evt_q;
  assign lnk.buffer_write_pointer = wp_q;
  assign lnk.buffer_read_pointer = rp_q;
endmodule

// file: common/tmbw_pkg.sv
// Shared constants and types for the trace-to-memory buffer writer
package tmbw_pkg;
  localparam int ADDR_W = 32;
  localparam int BYTE_W = 8;
  localparam int MSI_DW = 32;
  localparam int EVT_W = 3;
  localparam int EVT_TRIG = 0;
  localparam int EVT_ABORT = 1;
  localparam int EVT_FULL = 2;
  localparam int WORD_SHIFT = 2;
  localparam int ALIGN_W = 2;
  localparam logic [ALIGN_W-1:0] ALIGN_ZERO = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 32'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0;
  localparam logic [1:0] MODE_CIRC = 2'h0;
  localparam logic [1:0] MODE_SWF1 = 2'h1;
  localparam logic [1:0] MODE_SWF2 = 2'h2;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [7:0] EMPTY_BYTE = 8'h00;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int MEM_AW = 8;
  typedef enum logic [2:0] {
    ST_DISABLED = 3'h0,
    ST_RUNNING = 3'h1,
    ST_STOPPING = 3'h2,
    ST_STOPPED = 3'h3,
    ST_DISABLING = 3'h4
  } tmbw_state_t;
endpackage

// file: common/tmbw_if.sv
// Link between the buffer writer and its trace source, memory and software
interface tmbw_if;
  logic trc_valid;
  logic trc_ready;
  logic [tmbw_pkg::BYTE_W-1:0] trc_data;
  logic trc_trigger;
  logic mem_wr_valid;
  logic mem_wr_ready;
  logic [tmbw_pkg::ADDR_W-1:0] mem_wr_addr;
  logic [tmbw_pkg::BYTE_W-1:0] mem_wr_data;
  logic mem_wr_resp_valid;
  logic mem_wr_resp_err;
  logic mem_rd_valid;
  logic mem_rd_ready;
  logic [tmbw_pkg::ADDR_W-1:0] mem_rd_addr;
  logic mem_rd_resp_valid;
  logic [tmbw_pkg::BYTE_W-1:0] mem_rd_data;
  logic msi_valid;
  logic msi_ready;
  logic [tmbw_pkg::ADDR_W-1:0] msi_addr;
  logic [tmbw_pkg::MSI_DW-1:0] msi_data;
  logic capture_enable_control;
  logic [1:0] mode;
  logic [tmbw_pkg::ADDR_W-1:0] buffer_base_address;
  logic [tmbw_pkg::ADDR_W-1:0] buffer_size_words;
  logic [tmbw_pkg::ADDR_W-1:0] buffer_watermark_words;
  logic wp_load_valid;
  logic [tmbw_pkg::ADDR_W-1:0] wp_load_value;
  logic msi_enable;
  logic [tmbw_pkg::ADDR_W-1:0] msi_addr_cfg;
  logic [tmbw_pkg::MSI_DW-1:0] msi_data_cfg;
  logic [tmbw_pkg::EVT_W-1:0] evt_clear;
  logic rd_req;
  logic rd_valid;
  logic [tmbw_pkg::BYTE_W-1:0] buffer_read_data_port;
  logic rd_empty;
  logic software_consumed_pointer_update;
  logic [tmbw_pkg::ADDR_W-1:0] consumed_ptr;
  logic buffer_full_flag;
  logic capt_ready;
  logic [tmbw_pkg::EVT_W-1:0] evt_status;
  logic [tmbw_pkg::ADDR_W-1:0] buffer_write_pointer;
  logic [tmbw_pkg::ADDR_W-1:0] buffer_read_pointer;

  modport dev (
    input trc_valid, trc_data, trc_trigger, mem_wr_ready,
    input mem_wr_resp_valid, mem_wr_resp_err, mem_rd_ready,
    input mem_rd_resp_valid, mem_rd_data, msi_ready,
    input capture_enable_control, mode, buffer_base_address,
    input buffer_size_words, buffer_watermark_words, wp_load_valid,
    input wp_load_value, msi_enable, msi_addr_cfg, msi_data_cfg,
    input evt_clear, rd_req, software_consumed_pointer_update,
    input consumed_ptr,
    output trc_ready, mem_wr_valid, mem_wr_addr, mem_wr_data,
    output mem_rd_valid, mem_rd_addr, msi_valid, msi_addr, msi_data,
    output rd_valid, buffer_read_data_port, rd_empty, buffer_full_flag,
    output capt_ready, evt_status, buffer_write_pointer,
    output buffer_read_pointer
  );
  modport host (
    output trc_valid, trc_data, trc_trigger, mem_wr_ready,
    output mem_wr_resp_valid, mem_wr_resp_err, mem_rd_ready,
    output mem_rd_resp_valid, mem_rd_data, msi_ready,
    output capture_enable_control, mode, buffer_base_address,
    output buffer_size_words, buffer_watermark_words, wp_load_valid,
    output wp_load_value, msi_enable, msi_addr_cfg, msi_data_cfg,
    output evt_clear, rd_req, software_consumed_pointer_update,
    output consumed_ptr,
    input trc_ready, mem_wr_valid, mem_wr_addr, mem_wr_data,
    input mem_rd_valid, mem_rd_addr, msi_valid, msi_addr, msi_data,
    input rd_valid, buffer_read_data_port, rd_empty, buffer_full_flag,
    input capt_ready, evt_status, buffer_write_pointer,
    input buffer_read_pointer
  );
endinterface

// file: core/tmbw_host.sv
// Far end: trace source FIFO, memory target and software access agent
module tmbw_fifo #(
  parameter int WIDTH = tmbw_pkg::FIFO_W,
  parameter int DEPTH = tmbw_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  always_comb begin
    in_ready = (wr_q - rd_q) != (PW + 1)'(DEPTH);
    out_valid = wr_q != rd_q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + (PW + 1)'(1) : wr_q;
    rd_d = pop ? rd_q + (PW + 1)'(1) : rd_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (ce) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      mem_q[wr_q[PW-1:0]] <= in_data;
    end
  end

  assign out_data = mem_q[rd_q[PW-1:0]];
endmodule

module tmbw_host (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [tmbw_pkg::BYTE_W-1:0] src_data,
  input wire logic src_trigger,
  input wire logic capture_enable_control,
  input wire logic [1:0] mode,
  input wire logic [tmbw_pkg::ADDR_W-1:0] buffer_base_address,
  input wire logic [tmbw_pkg::ADDR_W-1:0] buffer_size_words,
  input wire logic [tmbw_pkg::ADDR_W-1:0] buffer_watermark_words,
  input wire logic wp_load_valid,
  input wire logic [tmbw_pkg::ADDR_W-1:0] wp_load_value,
  input wire logic msi_enable,
  input wire logic [tmbw_pkg::ADDR_W-1:0] msi_addr_cfg,
  input wire logic [tmbw_pkg::MSI_DW-1:0] msi_data_cfg,
  input wire logic [tmbw_pkg::EVT_W-1:0] evt_clear,
  input wire logic mem_stall,
  input wire logic sw_rd_req,
  output logic sw_rd_valid,
  output logic [tmbw_pkg::BYTE_W-1:0] sw_rd_data,
  output logic sw_rd_empty,
  input wire logic sw_peek_req,
  input wire logic [tmbw_pkg::MEM_AW-1:0] sw_peek_addr,
  output logic sw_peek_valid,
  output logic [tmbw_pkg::BYTE_W-1:0] sw_peek_data,
  input wire logic sw_consumed_valid,
  input wire logic [tmbw_pkg::ADDR_W-1:0] sw_consumed_ptr,
  output logic full_flag,
  output logic capt_ready,
  output logic [tmbw_pkg::EVT_W-1:0] evt_status,
  output logic msi_seen,
  tmbw_if.host lnk
);
  localparam int MAW = tmbw_pkg::MEM_AW;
  localparam int BW = tmbw_pkg::BYTE_W;
  logic [BW-1:0] mem_q [2**MAW];
  logic wresp_q, wresp_d, werr_q, werr_d, wtake;
  logic rresp_q, rresp_d;
  logic [BW-1:0] rdat_q, rdat_d, peek_q, peek_d;
  logic peek_vld_q, peek_vld_d, msi_q, msi_d, peek_ok;

  // Bytes pass unaltered so the source's alignment markers survive
  tmbw_fifo #(
    .WIDTH(tmbw_pkg::FIFO_W),
    .DEPTH(tmbw_pkg::FIFO_DEPTH)
  ) i_tmbw_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data(src_data),
    .out_valid(lnk.trc_valid),
    .out_ready(lnk.trc_ready),
    .out_data(lnk.trc_data)
  );

  always_comb begin
    wtake = lnk.mem_wr_valid && !mem_stall;
    wresp_d = wtake;
    werr_d = wtake && (lnk.mem_wr_addr[tmbw_pkg::ADDR_W-1:MAW] != '0);
    rresp_d = lnk.mem_rd_valid && !mem_stall;
    rdat_d = rresp_d ? mem_q[lnk.mem_rd_addr[MAW-1:0]] : rdat_q;
    // Circular contents are only valid once capture has halted
    peek_ok = (mode != tmbw_pkg::MODE_CIRC) || lnk.capt_ready;
    peek_vld_d = sw_peek_req && peek_ok;
    peek_d = peek_vld_d ? mem_q[sw_peek_addr] : peek_q;
    msi_d = lnk.msi_valid;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wresp_q <= 1'b0;
      werr_q <= 1'b0;
      rresp_q <= 1'b0;
      rdat_q <= '0;
      peek_q <= '0;
      peek_vld_q <= 1'b0;
      msi_q <= 1'b0;
    end else if (ce) begin
      wresp_q <= wresp_d;
      werr_q <= werr_d;
      rresp_q <= rresp_d;
      rdat_q <= rdat_d;
      peek_q <= peek_d;
      peek_vld_q <= peek_vld_d;
      msi_q <= msi_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && wtake && !werr_d) begin
      mem_q[lnk.mem_wr_addr[MAW-1:0]] <= lnk.mem_wr_data;
    end
  end

  assign lnk.trc_trigger = src_trigger;
  assign lnk.mem_wr_ready = !mem_stall;
  assign lnk.mem_wr_resp_valid = wresp_q;
  assign lnk.mem_wr_resp_err = werr_q;
  assign lnk.mem_rd_ready = !mem_stall;
  assign lnk.mem_rd_resp_valid = rresp_q;
  assign lnk.mem_rd_data = rdat_q;
  assign lnk.msi_ready = 1'b1;
  assign lnk.capture_enable_control = capture_enable_control;
  assign lnk.mode = mode;
  assign lnk.buffer_base_address = buffer_base_address;
  assign lnk.buffer_size_words = buffer_size_words;
  assign lnk.buffer_watermark_words = buffer_watermark_words;
  assign lnk.wp_load_valid = wp_load_valid;
  assign lnk.wp_load_value = wp_load_value;
  assign lnk.msi_enable = msi_enable;
  assign lnk.msi_addr_cfg = msi_addr_cfg;
  assign lnk.msi_data_cfg = msi_data_cfg;
  assign lnk.evt_clear = evt_clear;
  assign lnk.rd_req = sw_rd_req && (mode == tmbw_pkg::MODE_SWF1);
  assign lnk.software_consumed_pointer_update = sw_consumed_valid
    && (mode == tmbw_pkg::MODE_SWF2);
  assign lnk.consumed_ptr = sw_consumed_ptr;
  assign sw_rd_valid = lnk.rd_valid;
  assign sw_rd_data = lnk.buffer_read_data_port;
  assign sw_rd_empty = lnk.rd_empty;
  assign sw_peek_valid = peek_vld_q;
  assign sw_peek_data = peek_q;
  assign full_flag = lnk.buffer_full_flag;
  assign capt_ready = lnk.capt_ready;
  assign evt_status = lnk.evt_status;
  assign msi_seen = msi_q;
endmodule

// file: dv/tmbw_checker.sv
// Assertions on the buffer writer link
module tmbw_checker (
  input logic ref_clk,
  input logic reset_n,
  input logic [1:0] mode,
  input logic trc_valid,
  input logic trc_ready,
  input logic [7:0] trc_data,
  input logic mem_wr_valid,
  input logic mem_wr_ready,
  input logic [31:0] mem_wr_addr,
  input logic [7:0] mem_wr_data,
  input logic mem_wr_resp_valid,
  input logic mem_wr_resp_err,
  input logic mem_rd_resp_valid,
  input logic [7:0] mem_rd_data,
  input logic rd_valid,
  input logic [7:0] buffer_read_data_port,
  input logic [31:0] buffer_base_address,
  input logic [31:0] buffer_size_words,
  input logic [31:0] buffer_write_pointer,
  input logic [31:0] buffer_read_pointer,
  input logic software_consumed_pointer_update,
  input logic [31:0] consumed_ptr,
  input logic capt_ready,
  input logic [2:0] evt_status
);
  logic take;
  logic [31:0] end_a, nxt;
  assign take = trc_valid && trc_ready;
  assign end_a = buffer_base_address +
    (buffer_size_words << tmbw_pkg::WORD_SHIFT);
  assign nxt = buffer_write_pointer + tmbw_pkg::ADDR_ONE;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  AST_WR_DATA: assert property (take |=> mem_wr_valid &&
    mem_wr_data == $past(trc_data)) else $error("wr data");
  AST_WR_ADDR: assert property (take |=>
    mem_wr_addr == $past(buffer_write_pointer)) else $error("wr addr");
  AST_WP_STEP: assert property (take && nxt != end_a |=>
    buffer_write_pointer == $past(nxt)) else $error("wp step");
  AST_WP_WRAP: assert property (take && nxt == end_a |=>
    buffer_write_pointer == buffer_base_address) else $error("no wrap");
  AST_WR_HOLD: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("wr hold");
  AST_ONE_OUT: assert property (mem_wr_valid |-> !trc_ready)
    else $error("two out");
  AST_ABORT: assert property (mem_wr_resp_valid && mem_wr_resp_err |->
    ##[1:2] evt_status[tmbw_pkg::EVT_ABORT]) else $error("no abort");
  AST_RD_DATA: assert property (mem_rd_resp_valid |=> rd_valid &&
    buffer_read_data_port == $past(mem_rd_data)) else $error("rd data");
  AST_RP_LOAD: assert property (software_consumed_pointer_update &&
    mode == tmbw_pkg::MODE_SWF2 |=> buffer_read_pointer ==
    $past(consumed_ptr)) else $error("rp load");
  AST_RUN: assert property (trc_ready |-> !capt_ready)
    else $error("not running");
endmodule

// file: dv/tmbw_test.sv
// Bench joining both ends
module tmbw_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, reset_n = 1'h0, stop_event = 1'h0;
  logic src_valid = 1'h0, src_trigger = 1'h0, mem_stall = 1'h0;
  logic capture_enable_control = 1'h0, wp_load_valid = 1'h0;
  logic msi_enable = 1'h1, sw_rd_req = 1'h0, sw_peek_req = 1'h0;
  logic sw_consumed_valid = 1'h0, fmt_en = 1'h0;
  logic [1:0] mode = 2'h0;
  logic [7:0] src_data = 8'h00, sw_peek_addr = 8'h00;
  logic [31:0] buffer_base_address = 32'h0, buffer_size_words = 32'h2;
  logic [31:0] buffer_watermark_words = 32'h0, wp_load_value = 32'h0;
  logic [31:0] msi_addr_cfg = 32'h1000, msi_data_cfg = 32'h5a;
  logic [31:0] sw_consumed_ptr = 32'h0;
  logic [2:0] evt_clear = 3'h0;
  logic src_ready, sw_rd_valid, sw_rd_empty, sw_peek_valid, full_flag;
  logic capt_ready, msi_seen;
  logic [7:0] sw_rd_data, sw_peek_data;
  logic [2:0] evt_status;
  tmbw_pkg::tmbw_state_t state;
  int n_fail = 0, total_checks = 0, cyc = 0, n_wr = 0, n_msi = 0, acc;
  tmbw_if lnk ();
  tmbw_device i_tmbw_device (.ref_clk, .reset_n, .ce(1'h1), .fmt_en,
    .stop_event, .state, .lnk(lnk.dev));
  tmbw_host i_tmbw_host (.ce(1'h1), .lnk(lnk.host), .*);
  tmbw_checker i_tmbw_checker (.ref_clk, .reset_n, .mode(lnk.mode),
    .trc_valid(lnk.trc_valid), .trc_ready(lnk.trc_ready),
    .trc_data(lnk.trc_data), .mem_wr_valid(lnk.mem_wr_valid),
    .mem_wr_ready(lnk.mem_wr_ready), .mem_wr_addr(lnk.mem_wr_addr),
    .mem_wr_data(lnk.mem_wr_data), .mem_wr_resp_valid(lnk.mem_wr_resp_valid),
    .mem_wr_resp_err(lnk.mem_wr_resp_err),
    .mem_rd_resp_valid(lnk.mem_rd_resp_valid), .mem_rd_data(lnk.mem_rd_data),
    .rd_valid(lnk.rd_valid), .buffer_read_data_port(lnk.buffer_read_data_port),
    .buffer_base_address(lnk.buffer_base_address),
    .buffer_size_words(lnk.buffer_size_words),
    .buffer_write_pointer(lnk.buffer_write_pointer),
    .buffer_read_pointer(lnk.buffer_read_pointer),
    .software_consumed_pointer_update(lnk.software_consumed_pointer_update),
    .consumed_ptr(lnk.consumed_ptr), .capt_ready(lnk.capt_ready),
    .evt_status(lnk.evt_status));
  always #12.5 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (lnk.mem_wr_valid === 1'h1 && lnk.mem_wr_ready === 1'h1)
      n_wr <= n_wr + 1;
    if (msi_seen === 1'h1)
      n_msi <= n_msi + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wait_wr(input int t);
    for (int k = 0; k < 400 && n_wr < t; k++) @(posedge ref_clk);
  endtask
  task automatic wait_st(input tmbw_pkg::tmbw_state_t s);
    for (int k = 0; k < 100 && state !== s; k++) @(posedge ref_clk);
    chk("state", s, state);
  endtask
  task automatic send(input int n);
    acc = 0;
    src_valid <= 1'h1;
    src_data <= 8'h00;
    for (int k = 0; k < 200 && acc < n; k++) begin
      @(posedge ref_clk);
      if (src_ready === 1'h1) begin
        acc++;
        src_data <= acc[7:0];
      end
    end
    src_valid <= 1'h0;
  endtask
  task automatic start(input logic [1:0] m, input logic [31:0] b, w, p);
    mode <= m;
    buffer_base_address <= b;
    buffer_watermark_words <= w;
    wp_load_value <= p;
    wp_load_valid <= 1'h1;
    evt_clear <= 3'h7;
    @(posedge ref_clk);
    wp_load_valid <= 1'h0;
    evt_clear <= 3'h0;
    capture_enable_control <= 1'h1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic halt();
    capture_enable_control <= 1'h0;
    wait_st(tmbw_pkg::ST_DISABLED);
  endtask
  task automatic peek(input int a, input int d);
    sw_peek_addr <= a[7:0];
    sw_peek_req <= 1'h1;
    @(posedge ref_clk);
    sw_peek_req <= 1'h0;
    @(posedge ref_clk);
    chk("peek vld", 32'h1, sw_peek_valid);
    chk("peek data", d[7:0], sw_peek_data);
  endtask
  task automatic rd(input logic e, input logic [7:0] d);
    sw_rd_req <= 1'h1;
    @(posedge ref_clk);
    sw_rd_req <= 1'h0;
    for (int k = 0; k < 10 && sw_rd_valid !== 1'h1; k++) @(posedge ref_clk);
    chk("rd empty", e, sw_rd_empty);
    chk("rd data", d, sw_rd_data);
  endtask
  // Circular: stalled memory, wraps, padded stop
  task automatic t_circ();
    mem_stall <= 1'h1;
    start(tmbw_pkg::MODE_CIRC, 32'h0, 32'h0, 32'h5);
    send(40);
    chk("fill", 32'h1, acc >= 32 && acc <= 33);
    mem_stall <= 1'h0;
    wait_wr(acc);
    stop_event <= 1'h1;
    fmt_en <= 1'h1;
    @(posedge ref_clk);
    stop_event <= 1'h0;
    wait_st(tmbw_pkg::ST_STOPPED);
    chk("wp", (acc + 8) / 4 * 4 % 8, lnk.buffer_write_pointer);
    chk("full", 32'h1, full_flag);
    peek((4 + acc) % 8, acc - 1);
    peek(5, ((acc - 1) / 8) * 8);
    peek(6, tmbw_pkg::PAD_BYTE);
    fmt_en <= 1'h0;
    halt();
  endtask
  // Trigger, then a write error aborts
  task automatic t_abort();
    int m0;
    buffer_size_words <= 32'h3;
    start(tmbw_pkg::MODE_CIRC, 32'hfc, 32'h0, 32'hfe);
    m0 = n_msi;
    chk("full clr", 32'h0, full_flag);
    src_trigger <= 1'h1;
    @(posedge ref_clk);
    src_trigger <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk("trigger", 32'h1, evt_status[tmbw_pkg::EVT_TRIG]);
    evt_clear <= 3'h1;
    @(posedge ref_clk);
    evt_clear <= 3'h0;
    repeat (2) @(posedge ref_clk);
    chk("trigger clr", 32'h0, evt_status[tmbw_pkg::EVT_TRIG]);
    send(3);
    wait_st(tmbw_pkg::ST_STOPPED);
    chk("abort", 32'h1, evt_status[tmbw_pkg::EVT_ABORT]);
    chk("wp", 32'h101, lnk.buffer_write_pointer);
    @(posedge ref_clk);
    chk("msi", 32'h2, n_msi - m0);
    chk("msi a", msi_addr_cfg, lnk.msi_addr);
    chk("msi d", msi_data_cfg, lnk.msi_data);
    halt();
    buffer_size_words <= 32'h2;
  endtask
  // Mode one: port reads; writes hold while full
  task automatic t_swf1();
    int w0;
    start(tmbw_pkg::MODE_SWF1, 32'h20, 32'h1, 32'h24);
    rd(1'h1, tmbw_pkg::EMPTY_BYTE);
    w0 = n_wr;
    send(9);
    wait_wr(w0 + 8);
    repeat (10) @(posedge ref_clk);
    chk("held", 32'h8, n_wr - w0);
    chk("full", 32'h1, full_flag);
    chk("full evt", 32'h1, evt_status[tmbw_pkg::EVT_FULL]);
    rd(1'h0, 8'h00);
    rd(1'h0, 8'h01);
    wait_wr(w0 + 9);
    repeat (4) @(posedge ref_clk);
    chk("wp", 32'h25, lnk.buffer_write_pointer);
    chk("rp", 32'h26, lnk.buffer_read_pointer);
    halt();
  endtask
  // Mode two: consumed pointer frees space
  task automatic t_swf2();
    int w0;
    start(tmbw_pkg::MODE_SWF2, 32'h40, 32'h0, 32'h40);
    w0 = n_wr;
    send(10);
    wait_wr(w0 + 8);
    repeat (10) @(posedge ref_clk);
    chk("held", 32'h8, n_wr - w0);
    chk("full", 32'h1, full_flag);
    sw_consumed_ptr <= 32'h43;
    sw_consumed_valid <= 1'h1;
    @(posedge ref_clk);
    sw_consumed_valid <= 1'h0;
    wait_wr(w0 + 10);
    repeat (4) @(posedge ref_clk);
    chk("rp", 32'h43, lnk.buffer_read_pointer);
    chk("wp", 32'h42, lnk.buffer_write_pointer);
    chk("full", 32'h0, full_flag);
    halt();
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    t_circ();
    t_abort();
    t_swf1();
    t_swf2();
    tally_and_finish();
  end
endmodule
